// ==== idep_drive_model.sv ====
// Behavioural model of an attached disk drive on the drive-side port
`timescale 1ns/1ps
module idep_drive_model (
	input wire logic clk,
	input wire logic [2:0] addr,
	input wire logic [3:0] sel_n,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic [15:0] dd,
	input wire logic wide_en,
	input wire logic [7:0] stall,
	output logic [15:0] dd_drv,
	output logic [15:0] dd_en,
	output logic ready,
	output logic wide_n
);
	logic [15:0] mem [0:31];
	logic [4:0] idx;
	logic hit;
	logic [7:0] cnt = 8'h00;
	always_comb begin
		hit = 1'b1;
		case (sel_n)
			4'he: idx = {2'h0, addr};
			4'hd: idx = {2'h1, addr};
			4'hb: idx = {2'h2, addr};
			4'h7: idx = {2'h3, addr};
			default: begin
				idx = 5'h00;
				hit = 1'b0;
			end
		endcase
	end
	assign wide_n = !(wide_en && hit && addr == 3'h0);
	// drive data while read low; narrow leaves upper byte to the pull-up
	assign dd_drv = mem[idx];
	assign dd_en = (hit && !rd_n) ? (wide_n ? 16'h00ff : 16'hffff) : 16'h0000;
	always @(posedge wr_n) begin
		if (hit)
			mem[idx] <= dd;
	end
	always @(posedge clk) begin
		cnt <= (!rd_n || !wr_n) ? cnt + 8'h01 : 8'h00;
	end
	// negate to stretch, otherwise driven high
	assign ready = !((!rd_n || !wr_n) && cnt < stall);
endmodule // idep_drive_model

// ==== idep_drive_port.sv ====
// Drive-side port: register cycles toward the disk drives and reset straps
`timescale 1ns/1ps
module idep_drive_port
	import idep_pkg::*;
(
	input wire logic CORE_CLK,
	input wire logic NRST,
	input wire logic REQ,
	input wire logic REQ_WR,
	input wire logic REQ_SEC,
	input wire logic REQ_CTL,
	input wire logic [2:0] REQ_ADDR,
	input wire logic [15:0] REQ_WDATA,
	output logic BUSY,
	output logic DONE,
	output logic [15:0] RDATA,
	output logic RWIDE,
	output logic [1:0] DRV_ADDR_LOW_O,
	output logic DRV_ADDR_LOW_OE,
	input wire logic [1:0] DRV_ADDR_LOW_I,
	output logic DRV_ADDR_TOP_O,
	output logic DRV_ADDR_TOP_OE,
	input wire logic DRV_ADDR_TOP_I,
	output logic [3:0] BLOCK_SEL_N_O,
	output logic BLOCK_SEL_OE,
	input wire logic [3:0] BLOCK_SEL_N_I,
	input wire logic TEST_MODE_STRAP_N,
	output logic DRV_READ_STROBE_N,
	output logic DRV_WRITE_STROBE_N,
	input wire logic CHANNEL_READY_IN,
	input wire logic WIDE_XFER_IND_N,
	output logic [15:0] DISK_DATA_BUS_O,
	output logic [15:0] DISK_DATA_BUS_OE,
	input wire logic [15:0] DISK_DATA_BUS_I,
	output logic STRAPS_VALID,
	output logic [1:0] TIMING_MODE,
	output logic TEST_MODE,
	output logic [1:0] TEST_SEL,
	output logic [7:0] MISC_CFG,
	output logic [7:0] STRAP_CFG,
	output logic ADDR_RELOCATE,
	output logic IRQ_SCHEME
);
	idep_strap_if st ();

	idep_straps u_straps (
		.clk(CORE_CLK),
		.rst_n(NRST),
		.addr_low_pin(DRV_ADDR_LOW_I),
		.addr_top_pin(DRV_ADDR_TOP_I),
		.cs_pin_n(BLOCK_SEL_N_I),
		.test_pin_n(TEST_MODE_STRAP_N),
		.st(st)
	);

	// strobe width from the cycle time, less setup and recovery
	function automatic logic [6:0] strobe_len(input logic [1:0] mode, input logic test);
		logic [6:0] cyc;
		cyc = CYC_MODE0;
		if (!test && mode == MODE_383) begin
			cyc = CYC_MODE1;
		end else if (!test && mode == MODE_180) begin
			cyc = CYC_MODE3;
		end
		return cyc - SETUP_CYC - RECOV_CYC;
	endfunction

	idep_state_e state_q, state_d;
	logic [6:0] cnt_q, cnt_d;
	logic wr_q, wr_d;
	logic [2:0] addr_q, addr_d;
	logic [3:0] cs_n_q, cs_n_d;
	logic rd_n_q, rd_n_d, wr_n_q, wr_n_d;
	logic [15:0] wdata_q, wdata_d, doe_q, doe_d, rdata_q, rdata_d;
	logic done_q, done_d, rwide_q, rwide_d, busy_q, busy_d, pin_oe_q, pin_oe_d;
	logic rdy_s1_q, rdy_s2_q, wide_s1_q, wide_s2_q;
	logic [15:0] dd_s1_q, dd_s2_q;

	// Pins from the drive pass two flops before use
	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			rdy_s1_q <= 1'b1;
			rdy_s2_q <= 1'b1;
			wide_s1_q <= 1'b0;
			wide_s2_q <= 1'b0;
			dd_s1_q <= DATA_RESET;
			dd_s2_q <= DATA_RESET;
		end else begin
			rdy_s1_q <= CHANNEL_READY_IN;
			rdy_s2_q <= rdy_s1_q;
			wide_s1_q <= !WIDE_XFER_IND_N;
			wide_s2_q <= wide_s1_q;
			dd_s1_q <= DISK_DATA_BUS_I;
			dd_s2_q <= dd_s1_q;
		end
	end

	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		wr_d = wr_q;
		addr_d = addr_q;
		cs_n_d = cs_n_q;
		rd_n_d = rd_n_q;
		wr_n_d = wr_n_q;
		wdata_d = wdata_q;
		doe_d = doe_q;
		rdata_d = rdata_q;
		rwide_d = rwide_q;
		done_d = 1'b0;
		// shared pins driven only once straps are held
		pin_oe_d = st.valid;
		busy_d = (state_q != ST_IDLE) || !st.valid;
		unique case (state_q)
			ST_IDLE: begin
				if (REQ && st.valid) begin
					// address latched for the whole cycle
					addr_d = REQ_ADDR;
					wr_d = REQ_WR;
					wdata_d = REQ_WDATA;
					cnt_d = strobe_len(st.timing_mode, st.test_mode);
					// one block select from channel and block
					cs_n_d = CS_IDLE_N;
					cs_n_d[{REQ_SEC, REQ_CTL}] = 1'b0;
					busy_d = 1'b1;
					state_d = ST_SETUP;
				end
			end
			ST_SETUP: begin
				rd_n_d = wr_q;
				wr_n_d = !wr_q;
				// upper byte driven only for wide transfers
				doe_d = wr_q ? {(wide_s2_q ? BYTE_ALL : BYTE_ZERO), BYTE_ALL} : DATA_RESET;
				state_d = ST_STROBE;
			end
			ST_STROBE: begin
				doe_d = wr_q ? {(wide_s2_q ? BYTE_ALL : BYTE_ZERO), BYTE_ALL} : DATA_RESET;
				if (cnt_q > 7'h1) begin
					cnt_d = cnt_q - 7'h1;
				// stretch while the drive holds ready negated
				end else if (rdy_s2_q) begin
					rd_n_d = 1'b1;
					// rising edge of write strobe marks capture
					wr_n_d = 1'b1;
					// narrow reads return the low byte only
					rdata_d = wide_s2_q ? dd_s2_q : {BYTE_ZERO, dd_s2_q[7:0]};
					rwide_d = wide_s2_q;
					state_d = ST_RECOV;
				end
			end
			ST_RECOV: begin
				cs_n_d = CS_IDLE_N;
				doe_d = DATA_RESET;
				done_d = 1'b1;
				state_d = ST_IDLE;
			end
			default: begin
				state_d = ST_IDLE;
				cs_n_d = CS_IDLE_N;
				rd_n_d = 1'b1;
				wr_n_d = 1'b1;
				doe_d = DATA_RESET;
			end
		endcase
	end

	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			state_q <= ST_IDLE;
			cnt_q <= 7'h0;
			wr_q <= 1'b0;
			addr_q <= ADDR_RESET;
			cs_n_q <= CS_IDLE_N;
			rd_n_q <= 1'b1;
			wr_n_q <= 1'b1;
			wdata_q <= DATA_RESET;
			doe_q <= DATA_RESET;
			rdata_q <= DATA_RESET;
			rwide_q <= 1'b0;
			done_q <= 1'b0;
			busy_q <= 1'b1;
			pin_oe_q <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			wr_q <= wr_d;
			addr_q <= addr_d;
			cs_n_q <= cs_n_d;
			rd_n_q <= rd_n_d;
			wr_n_q <= wr_n_d;
			wdata_q <= wdata_d;
			doe_q <= doe_d;
			rdata_q <= rdata_d;
			rwide_q <= rwide_d;
			done_q <= done_d;
			busy_q <= busy_d;
			pin_oe_q <= pin_oe_d;
		end
	end

	// Strap results are registered inside the capture module and only read here
	always_comb begin
		BUSY = busy_q;
		DONE = done_q;
		RDATA = rdata_q;
		RWIDE = rwide_q;
		DRV_ADDR_LOW_O = addr_q[1:0];
		DRV_ADDR_TOP_O = addr_q[2];
		DRV_ADDR_LOW_OE = pin_oe_q;
		DRV_ADDR_TOP_OE = pin_oe_q;
		BLOCK_SEL_N_O = cs_n_q;
		BLOCK_SEL_OE = pin_oe_q;
		DRV_READ_STROBE_N = rd_n_q;
		DRV_WRITE_STROBE_N = wr_n_q;
		DISK_DATA_BUS_O = wdata_q;
		DISK_DATA_BUS_OE = doe_q;
		STRAPS_VALID = st.valid;
		TIMING_MODE = st.timing_mode;
		TEST_MODE = st.test_mode;
		TEST_SEL = st.test_sel;
		MISC_CFG = st.misc_cfg;
		STRAP_CFG = st.strap_cfg;
		ADDR_RELOCATE = st.addr_addr_relocate_strap;
		IRQ_SCHEME = st.irq_scheme;
	end

	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (!NRST);

	a_strobes_exclusive: assert property (!(!rd_n_q && !wr_n_q)) else $error("both strobes active");
	a_one_select: assert property ($onehot0(~cs_n_q)) else $error("more than one block select");
	a_strobe_has_select: assert property ((!rd_n_q || !wr_n_q) |-> cs_n_q != CS_IDLE_N) else $error("strobe without select");
	a_ready_stretch: assert property (state_q == ST_STROBE && cnt_q <= 7'h1 && !rdy_s2_q |=> (!rd_n_q || !wr_n_q)) else $error("strobe ended while not ready");
	a_pins_released: assert property (!st.valid |-> !pin_oe_q && doe_q == DATA_RESET) else $error("pins driven before straps held");
	a_start_cycle: assert property (REQ && state_q == ST_IDLE && st.valid |=> state_q == ST_SETUP ##1 (!rd_n_q || !wr_n_q)) else $error("request did not start a cycle");
	a_min_strobe: assert property ($fell(wr_n_q) |-> !wr_n_q [*8]) else $error("write strobe too short");
	a_narrow_read: assert property (done_q && !rwide_q && !wr_q |-> rdata_q[15:8] == BYTE_ZERO) else $error("narrow read upper byte set");
	a_done_pulse: assert property (done_q |=> !done_q && state_q == ST_IDLE) else $error("done not one cycle");
endmodule // idep_drive_port

// ==== idep_pkg.sv ====
// Shared constants and types for the drive-side port and its strap capture
package idep_pkg;
	localparam int CLK_PERIOD_NS = 8;
	localparam int T_MODE0_NS = 600;
	localparam int T_MODE1_NS = 383;
	localparam int T_MODE3_NS = 180;
	localparam logic [6:0] CYC_MODE0 = 7'((T_MODE0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [6:0] CYC_MODE1 = 7'((T_MODE1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [6:0] CYC_MODE3 = 7'((T_MODE3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [6:0] SETUP_CYC = 7'h01;
	localparam logic [6:0] RECOV_CYC = 7'h01;
	localparam logic [1:0] MODE_600 = 2'h0;
	localparam logic [1:0] MODE_383 = 2'h1;
	localparam logic [1:0] MODE_180 = 2'h3;
	localparam logic [1:0] STRAP_SYNC_LAST = 2'h2;
	localparam int MISC_PREFETCH_BIT = 6;
	localparam int STRAP_FREQ_BIT = 0;
	localparam int STRAP_LEGACY_BIT = 7;
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam logic [3:0] CS_IDLE_N = 4'hf;
	localparam logic [2:0] ADDR_RESET = 3'h0;
	localparam logic [15:0] DATA_RESET = 16'h0000;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [7:0] BYTE_ALL = 8'hff;
	// Chip select index: {channel, block}; channel 1 = secondary, block 1 = control
	localparam logic [1:0] CS_PRI_CMD = 2'h0;
	localparam logic [1:0] CS_PRI_CTL = 2'h1;
	localparam logic [1:0] CS_SEC_CMD = 2'h2;
	localparam logic [1:0] CS_SEC_CTL = 2'h3;
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_SETUP = 4'h2,
		ST_STROBE = 4'h4,
		ST_RECOV = 4'h8
	} idep_state_e;
endpackage

// ==== idep_strap_if.sv ====
// Strap values passed from the capture module to the port logic
`timescale 1ns/1ps
interface idep_strap_if;
	logic valid;
	logic [1:0] timing_mode;
	logic test_mode;
	logic [1:0] test_sel;
	logic [7:0] misc_cfg;
	logic [7:0] strap_cfg;
	logic addr_addr_relocate_strap;
	logic irq_scheme;
	modport prod (output valid, timing_mode, test_mode, test_sel, misc_cfg, strap_cfg, addr_addr_relocate_strap, irq_scheme);
	modport cons (input valid, timing_mode, test_mode, test_sel, misc_cfg, strap_cfg, addr_addr_relocate_strap, irq_scheme);
endinterface

// ==== idep_straps.sv ====
// Reset strap synchroniser and capture
`timescale 1ns/1ps
module idep_straps
	import idep_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [1:0] addr_low_pin,
	input wire logic addr_top_pin,
	input wire logic [3:0] cs_pin_n,
	input wire logic test_pin_n,
	idep_strap_if.prod st
);
	logic [7:0] s1_q, s2_q, s1_d, s2_d;
	logic [1:0] cnt_q, cnt_d;
	logic valid_q, valid_d;
	logic [1:0] mode_q, mode_d;
	logic test_q, test_d;
	logic prefetch_q, prefetch_d;
	logic freq_q, freq_d;
	logic legacy_q, legacy_d;
	logic addr_relocate_strap_q, addr_relocate_strap_d;
	logic irqs_q, irqs_d;

	always_comb begin
		s1_d = {test_pin_n, cs_pin_n, addr_top_pin, addr_low_pin};
		s2_d = s1_q;
		cnt_d = cnt_q;
		valid_d = valid_q;
		mode_d = mode_q;
		test_d = test_q;
		prefetch_d = prefetch_q;
		freq_d = freq_q;
		legacy_d = legacy_q;
		addr_relocate_strap_d = addr_relocate_strap_q;
		irqs_d = irqs_q;
		if (!valid_q) begin
			if (cnt_q != STRAP_SYNC_LAST) begin
				cnt_d = cnt_q + 2'h1;
			end else begin
				valid_d = 1'b1;
				mode_d = s2_q[1:0];
				prefetch_d = s2_q[2];
				freq_d = s2_q[3 + CS_PRI_CMD];
				legacy_d = s2_q[3 + CS_PRI_CTL];
				addr_relocate_strap_d = s2_q[3 + CS_SEC_CMD];
				irqs_d = s2_q[3 + CS_SEC_CTL];
				test_d = !s2_q[7];
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_q <= CFG_RESET;
			s2_q <= CFG_RESET;
			cnt_q <= 2'h0;
			valid_q <= 1'b0;
			mode_q <= MODE_600;
			test_q <= 1'b0;
			prefetch_q <= 1'b0;
			freq_q <= 1'b0;
			legacy_q <= 1'b0;
			addr_relocate_strap_q <= 1'b0;
			irqs_q <= 1'b1;
		end else begin
			s1_q <= s1_d;
			s2_q <= s2_d;
			cnt_q <= cnt_d;
			valid_q <= valid_d;
			mode_q <= mode_d;
			test_q <= test_d;
			prefetch_q <= prefetch_d;
			freq_q <= freq_d;
			legacy_q <= legacy_d;
			addr_relocate_strap_q <= addr_relocate_strap_d;
			irqs_q <= irqs_d;
		end
	end

	always_comb begin
		st.valid = valid_q;
		st.timing_mode = mode_q;
		// mode pins pick a test mode
		st.test_mode = test_q;
		st.test_sel = test_q ? mode_q : 2'h0;
		st.misc_cfg = CFG_RESET;
		st.misc_cfg[MISC_PREFETCH_BIT] = prefetch_q;
		st.strap_cfg = CFG_RESET;
		st.strap_cfg[STRAP_FREQ_BIT] = freq_q;
		st.strap_cfg[STRAP_LEGACY_BIT] = legacy_q;
		st.addr_addr_relocate_strap = addr_relocate_strap_q;
		st.irq_scheme = irqs_q;
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	a_straps_held: assert property (valid_q && $past(valid_q) |-> $stable({mode_q, test_q, prefetch_q, freq_q, legacy_q, addr_relocate_strap_q, irqs_q})) else $error("strap changed after capture");
	a_capture_time: assert property ($rose(valid_q) |-> $past(cnt_q) == STRAP_SYNC_LAST && mode_q == $past(s2_q[1:0])) else $error("strap capture wrong");
endmodule // idep_straps

// ==== test_ide_drive_port_straps.sv ====
// Self-checking bench for the drive-side port and its reset straps
`timescale 1ns/1ps
module test_ide_drive_port_straps;
	import idep_pkg::*;
	logic CORE_CLK = 1'b0, NRST = 1'b0, REQ = 1'b0, REQ_WR = 1'b0, REQ_SEC = 1'b0, REQ_CTL = 1'b0;
	logic [2:0] REQ_ADDR = 3'h0;
	logic [15:0] REQ_WDATA = 16'h0000;
	logic BUSY, DONE, RWIDE, lo_oe, top_o, top_oe, sel_oe, rd_n, wr_n, valid, tmode, addr_relocate_strap, irq, ready, wide_n;
	logic [15:0] RDATA, dd_o, dd_oe, dd_pin, drv, en;
	logic [1:0] lo_o, tmg, tsel, lo_pin;
	logic [3:0] sel_o, sel_pin;
	logic [7:0] misc, scfg, s = 8'hfb, stall = 8'h00;
	logic wide_en = 1'b0, top_pin;
	int n_fail = 0, check_count = 0;
	// Undriven shared pins show the strap resistors; the data bus is pulled up
	assign lo_pin = lo_oe ? lo_o : s[1:0];
	assign top_pin = top_oe ? top_o : s[2];
	assign sel_pin = sel_oe ? sel_o : s[6:3];
	assign dd_pin = (dd_oe & dd_o) | (~dd_oe & ((en & drv) | ~en));
	always #4 CORE_CLK = ~CORE_CLK;
	idep_drive_port i_idep_drive_port (.CORE_CLK(CORE_CLK), .NRST(NRST), .REQ(REQ), .REQ_WR(REQ_WR),
		.REQ_SEC(REQ_SEC), .REQ_CTL(REQ_CTL), .REQ_ADDR(REQ_ADDR), .REQ_WDATA(REQ_WDATA), .BUSY(BUSY),
		.DONE(DONE), .RDATA(RDATA), .RWIDE(RWIDE), .DRV_ADDR_LOW_O(lo_o), .DRV_ADDR_LOW_OE(lo_oe),
		.DRV_ADDR_LOW_I(lo_pin), .DRV_ADDR_TOP_O(top_o), .DRV_ADDR_TOP_OE(top_oe), .DRV_ADDR_TOP_I(top_pin),
		.BLOCK_SEL_N_O(sel_o), .BLOCK_SEL_OE(sel_oe), .BLOCK_SEL_N_I(sel_pin), .TEST_MODE_STRAP_N(s[7]),
		.DRV_READ_STROBE_N(rd_n), .DRV_WRITE_STROBE_N(wr_n), .CHANNEL_READY_IN(ready),
		.WIDE_XFER_IND_N(wide_n), .DISK_DATA_BUS_O(dd_o), .DISK_DATA_BUS_OE(dd_oe), .DISK_DATA_BUS_I(dd_pin),
		.STRAPS_VALID(valid), .TIMING_MODE(tmg), .TEST_MODE(tmode), .TEST_SEL(tsel), .MISC_CFG(misc),
		.STRAP_CFG(scfg), .ADDR_RELOCATE(addr_relocate_strap), .IRQ_SCHEME(irq));
	idep_drive_model i_idep_drive_model (.clk(CORE_CLK), .addr({top_pin, lo_pin}), .sel_n(sel_pin),
		.rd_n(rd_n), .wr_n(wr_n), .dd(dd_pin), .wide_en(wide_en), .stall(stall), .dd_drv(drv), .dd_en(en),
		.ready(ready), .wide_n(wide_n));
	task automatic complete_run;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic check_straps;
		check(16'(tmode), 16'(!s[7]));
		check(16'(tsel), 16'(s[7] ? 2'h0 : s[1:0]));
		if (s[7])
			check(16'(tmg), 16'(s[1:0]));
		check(16'(misc), {8'h00, 1'b0, s[2], 6'h00});
		check(16'(scfg), {8'h00, s[4], 6'h00, s[3]});
		check(16'(addr_relocate_strap), 16'(s[5]));
		check(16'(irq), 16'(s[6]));
		check(16'(lo_oe & top_oe & sel_oe), 16'h0001);
		check(16'(valid), 16'h0001);
	endtask
	task automatic reset_to(input logic [7:0] v);
		int n;
		@(negedge CORE_CLK);
		NRST = 1'b0;
		s = v;
		repeat (2) @(negedge CORE_CLK);
		check(16'({lo_oe, top_oe, sel_oe}), 16'h0000);
		NRST = 1'b1;
		for (n = 0; n < 20 && BUSY !== 1'b0; n++)
			@(negedge CORE_CLK);
		check_straps();
	endtask
	// Strobe length expected from the strap timing code, in whole cycles less setup and recovery
	function automatic int slen(input logic [7:0] v);
		int ns;
		ns = (!v[7] || v[1:0] == 2'h2 || v[1:0] == 2'h0) ? T_MODE0_NS : (v[1:0] == 2'h1 ? T_MODE1_NS : T_MODE3_NS);
		return (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS - 2;
	endfunction
	task automatic xfer(input logic wr, input logic [1:0] cs, input logic [2:0] a, input logic [15:0] wd,
		output int len);
		int n;
		len = 0;
		@(negedge CORE_CLK);
		{REQ, REQ_WR, REQ_SEC, REQ_CTL, REQ_ADDR, REQ_WDATA} = {1'b1, wr, cs, a, wd};
		@(negedge CORE_CLK);
		REQ = 1'b0;
		for (n = 0; n < 400 && DONE !== 1'b1; n++) begin
			if (rd_n === 1'b0 || wr_n === 1'b0) begin
				if (len == 0) begin
					check(16'({top_pin, lo_pin}), 16'(a));
					check(16'(sel_pin), {12'h000, ~(4'h1 << cs)});
					check(16'({BUSY, rd_n, wr_n}), wr ? 16'h0006 : 16'h0005);
					check(16'(dd_oe[7:0]), wr ? 16'h00ff : 16'h0000);
				end
				len++;
			end
			@(negedge CORE_CLK);
		end
		check(16'(DONE), 16'h0001);
		@(negedge CORE_CLK);
		check(16'(BUSY), 16'h0000);
	endtask
	initial begin
		int len, i;
		logic [7:0] mv [5];
		mv = '{8'ha0, 8'hdd, 8'hfb, 8'hc6, 8'h2e};
		for (i = 0; i < 5; i++) begin
			reset_to(mv[i]);
			xfer(1'b0, 2'(i), 3'(i), 16'h0000, len);
			check(16'(len), 16'(slen(mv[i])));
		end
		reset_to(8'hfb);
		for (i = 0; i < 4; i++) begin
			xfer(1'b1, 2'(i), 3'h5, {8'ha5, 8'(8'h3c + i)}, len);
			xfer(1'b0, 2'(i), 3'h5, 16'h0000, len);
			check(RDATA, {8'h00, 8'(8'h3c + i)});
		end
		wide_en = 1'b1;
		xfer(1'b1, 2'h0, 3'h0, 16'hc3a5, len);
		xfer(1'b0, 2'h0, 3'h0, 16'h0000, len);
		check(RDATA, 16'hc3a5);
		check(16'(RWIDE), 16'h0001);
		stall = 8'd40;
		xfer(1'b0, 2'h0, 3'h0, 16'h0000, len);
		check(16'(len >= 40 && len <= 45), 16'h0001);
		check(RDATA, 16'hc3a5);
		check_straps();
		complete_run();
	end
	// Whole run needs under a thousand cycles; this is far beyond that
	initial begin
		repeat (20000) @(posedge CORE_CLK);
		n_fail++;
		complete_run();
	end
endmodule // test_ide_drive_port_straps
